/* File: wdt_defs.vh */
`ifndef WDT_DEFS_VH
`define WDT_DEFS_VH

// register map (offset 0x0F is not a multiple of four: index times four)
`define WDT_CTRL_INDEX      8'h0F
`define WDT_CTRL_ADDR       12'h03C

// watchdog_control field positions
`define WDT_BIT_RESTART     0
`define WDT_BIT_RST_EN      1
`define WDT_BIT_RST_FLAG    2
`define WDT_BIT_IRQ_FLAG    3
`define WDT_BIT_SEL_LO      4
`define WDT_BIT_SEL_HI      5
`define WDT_BIT_IRQ_EN      6
`define WDT_BIT_POR_FLAG    7

// reset values
`define WDT_CTRL_RST        8'h00
`define WDT_PWR_RST         8'h80

// timing
`define WDT_RST_DELAY       10'h200
`define WDT_CNT_W           24
`define WDT_PRIO_LIMIT      2'h3

// last count of each interval select, counts run from zero
`define WDT_LAST_SEL0       24'h007FFF
`define WDT_LAST_SEL1       24'h03FFFF
`define WDT_LAST_SEL2       24'h1FFFFF
`define WDT_LAST_SEL3       24'hFFFFFF

`endif

/* File: wdt_interval_cnt.v */
`timescale 1ns/1ns
`include "wdt_defs.vh"
// ----------------------------------------
// interval counter
// ----------------------------------------
module wdt_interval_cnt (
  // clock and control
  input  wire        ref_clk_i,
  input  wire        ce_i,
  input  wire        clr_i,
  input  wire        run_i,
  input  wire [1:0]  sel_i,
  // result
  output reg         elapsed_o
);
  reg  [23:0] cnt_r;
  wire [23:0] last_w;

  // terminal count per interval select
  assign last_w = (sel_i == 2'h0) ? `WDT_LAST_SEL0 :
                  (sel_i == 2'h1) ? `WDT_LAST_SEL1 :
                  (sel_i == 2'h2) ? `WDT_LAST_SEL2 : `WDT_LAST_SEL3;

  // advance one per clock, pulse at the end of the interval
  always @(posedge ref_clk_i) begin
    if (ce_i) begin
      elapsed_o <= 1'b0;
      if (clr_i) begin
        cnt_r <= 24'h000000;
      end else if (run_i) begin
        if (cnt_r == last_w) begin
          cnt_r     <= 24'h000000;
          elapsed_o <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 24'h000001;
        end
      end
    end
  end
endmodule // wdt_interval_cnt

/* File: wdt_reset_delay.v */
`timescale 1ns/1ns
`include "wdt_defs.vh"
// ----------------------------------------
// reset delay countdown
// ----------------------------------------
module wdt_reset_delay (
  // clock and control
  input  wire        ref_clk_i,
  input  wire        ce_i,
  input  wire        clr_i,
  input  wire        start_i,
  input  wire        arm_i,
  // result
  output reg         fire_o
);
  reg  [9:0] cnt_r;
  reg        busy_r;

  // count 512 clocks after the start, cancelled when disarmed
  always @(posedge ref_clk_i) begin
    if (ce_i) begin
      fire_o <= 1'b0;
      if (clr_i || !arm_i) begin
        busy_r <= 1'b0;
        cnt_r  <= 10'h000;
      end else if (start_i && !busy_r) begin
        busy_r <= 1'b1;
        cnt_r  <= `WDT_RST_DELAY - 10'h001;
      end else if (busy_r) begin
        if (cnt_r == 10'h000) begin
          busy_r <= 1'b0;
          fire_o <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 10'h001;
        end
      end
    end
  end
endmodule // wdt_reset_delay

/* File: watchdog_timer_control.v */
// What this block does
// - writing restart bit clears interval count
// - restart bit always reads zero
// - elapse with reset enable resets 512 later
// - reset enable low: no reset, still counts
// - both enables low halt counter
// - enabling from halt restarts the interval counter
// - reset enable cleared by power reset or a software write of zero
// - reset flag set only by real reset
// - reset flag cleared by power reset or a software write of zero
// - irq flag set on elapse or software
// - irq when flag, enable, global, priority ok
// - flag set with reset enable schedules reset
// - select gives 2^15/18/21/24 clock intervals
// - changing select restarts the count
// - irq enable gates request and also keeps the counter running
// - power-on flag set only at power-on
// - every reset clears bits 0,3,4,5
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ns
`include "wdt_defs.vh"
module watchdog_timer_control (
  // clock, enable and resets
  input  wire        ref_clk_i,
  input  wire        clk_en_i,
  input  wire        sys_rst_i,
  input  wire        pwr_rst_i,
  // apb slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  input  wire [3:0]  pstrb_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  // interrupt controller side
  input  wire        global_irq_enable_i,
  input  wire [1:0]  priority_in_service_i,
  output reg         irq_o,
  // processor reset
  output reg         cpu_rst_o
);

  // ----------------------------------------
  // control register state
  // ----------------------------------------
  reg        reset_enable_bit_r;
  reg        irq_enable_bit_r;
  reg        watchdog_reset_flag_r;
  reg        interval_irq_flag_r;
  reg        interval_select_low_r;
  reg        interval_select_high_r;
  reg        power_on_flag_r;
  reg        restart_pulse_r;
  reg        por_seen_r;

  wire       wr_w;
  wire       rd_w;
  wire       hit_w;
  wire       elapsed_w;
  wire       fire_w;
  wire       running_w;
  wire       sel_change_w;
  wire       enable_from_halt_w;
  wire       cnt_clr_w;
  wire [7:0] ctrl_w;
  wire [7:0] wd_w;
  wire       any_rst_w;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  assign hit_w = (paddr_i == `WDT_CTRL_ADDR);
  assign wr_w  = psel_i && penable_i && pwrite_i && hit_w && pstrb_i[0] && !pready_o;
  assign rd_w  = psel_i && !penable_i && !pwrite_i;
  assign wd_w  = pwdata_i[7:0];
  assign any_rst_w = sys_rst_i || pwr_rst_i || cpu_rst_o;

  // readable view, restart bit reads zero
  assign ctrl_w = {power_on_flag_r, irq_enable_bit_r, interval_select_high_r,
                   interval_select_low_r, interval_irq_flag_r, watchdog_reset_flag_r,
                   reset_enable_bit_r, 1'b0};

  assign running_w = reset_enable_bit_r || irq_enable_bit_r;
  assign sel_change_w = wr_w && ((wd_w[`WDT_BIT_SEL_LO] != interval_select_low_r) ||
                        (wd_w[`WDT_BIT_SEL_HI] != interval_select_high_r));
  assign enable_from_halt_w = wr_w && !running_w &&
                              (wd_w[`WDT_BIT_RST_EN] || wd_w[`WDT_BIT_IRQ_EN]);
  assign cnt_clr_w = restart_pulse_r || sel_change_w || enable_from_halt_w || any_rst_w;

  // ----------------------------------------
  // apb response, one wait state
  // ----------------------------------------
  always @(posedge ref_clk_i) begin
    if (sys_rst_i || pwr_rst_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h00000000;
      pslverr_o <= 1'b0;
    end else if (clk_en_i) begin
      pready_o  <= psel_i && penable_i && !pready_o;
      pslverr_o <= psel_i && penable_i && !pready_o && !hit_w;
      if (rd_w) begin
        prdata_o <= hit_w ? {24'h000000, ctrl_w} : 32'h00000000;
      end
    end
  end

  // ----------------------------------------
  // power-domain bits: only power reset clears
  // ----------------------------------------
  always @(posedge ref_clk_i) begin
    if (pwr_rst_i) begin
      reset_enable_bit_r    <= 1'b0;
      irq_enable_bit_r      <= 1'b0;
      watchdog_reset_flag_r <= 1'b0;
      por_seen_r            <= 1'b1;
    end else if (clk_en_i) begin
      por_seen_r <= 1'b0;
      if (wr_w) begin
        reset_enable_bit_r <= wd_w[`WDT_BIT_RST_EN];
        irq_enable_bit_r   <= wd_w[`WDT_BIT_IRQ_EN];
      end
      // software may only clear, writing one does nothing
      if (fire_w) begin
        watchdog_reset_flag_r <= 1'b1;
      end else if (wr_w && !wd_w[`WDT_BIT_RST_FLAG]) begin
        watchdog_reset_flag_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // power-on flag: set at power-on, software clears
  // ----------------------------------------
  always @(posedge ref_clk_i) begin
    if (pwr_rst_i) begin
      power_on_flag_r <= 1'b1;
    end else if (clk_en_i) begin
      if (por_seen_r) begin
        power_on_flag_r <= 1'b1;
      end else if (wr_w && !wd_w[`WDT_BIT_POR_FLAG]) begin
        power_on_flag_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // bits cleared by every reset
  // ----------------------------------------
  always @(posedge ref_clk_i) begin
    if (any_rst_w) begin
      restart_pulse_r        <= 1'b0;
      interval_irq_flag_r    <= 1'b0;
      interval_select_low_r  <= 1'b0;
      interval_select_high_r <= 1'b0;
    end else if (clk_en_i) begin
      restart_pulse_r <= wr_w && wd_w[`WDT_BIT_RESTART];
      if (wr_w) begin
        interval_select_low_r  <= wd_w[`WDT_BIT_SEL_LO];
        interval_select_high_r <= wd_w[`WDT_BIT_SEL_HI];
      end
      // hardware set wins over a software clear
      if (elapsed_w) begin
        interval_irq_flag_r <= 1'b1;
      end else if (wr_w) begin
        interval_irq_flag_r <= wd_w[`WDT_BIT_IRQ_FLAG];
      end
    end
  end

  // ----------------------------------------
  // interval counter
  // ----------------------------------------
  wdt_interval_cnt u_interval (
    .ref_clk_i (ref_clk_i),
    .ce_i      (clk_en_i),
    .clr_i     (cnt_clr_w),
    .run_i     (running_w),
    .sel_i     ({interval_select_high_r, interval_select_low_r}),
    .elapsed_o (elapsed_w)
  );

  // ----------------------------------------
  // reset countdown from flag setting
  // ----------------------------------------
  wdt_reset_delay u_delay (
    .ref_clk_i (ref_clk_i),
    .ce_i      (clk_en_i),
    .clr_i     (any_rst_w),
    .start_i   (elapsed_w || (wr_w && wd_w[`WDT_BIT_IRQ_FLAG] && !interval_irq_flag_r)),
    .arm_i     (reset_enable_bit_r),
    .fire_o    (fire_w)
  );

  // ----------------------------------------
  // reset and interrupt outputs
  // ----------------------------------------
  always @(posedge ref_clk_i) begin
    if (sys_rst_i || pwr_rst_i) begin
      cpu_rst_o <= 1'b0;
      irq_o     <= 1'b0;
    end else if (clk_en_i) begin
      cpu_rst_o <= fire_w;
      irq_o     <= interval_irq_flag_r && irq_enable_bit_r && global_irq_enable_i &&
                   (priority_in_service_i == `WDT_PRIO_LIMIT);
    end
  end

endmodule // watchdog_timer_control

/* File: watchdog_checker_assertions.sv */
`timescale 1ns/1ns
`include "wdt_defs.vh"
// ----------------------------------------
// port checker
// ----------------------------------------
module watchdog_checker (
  // watched ports
  input wire logic        ref_clk_i,
  input wire logic        sys_rst_i,
  input wire logic        pwr_rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        global_irq_enable_i,
  input wire logic [1:0]  priority_in_service_i,
  input wire logic        irq_o,
  input wire logic        cpu_rst_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i | pwr_rst_i);
  a_read_bits: assert property
    (pready_o && !pwrite_i |-> prdata_o[31:8] == 24'h0 && !prdata_o[0]) else $error("bad read");
  a_apb_answer: assert property
    (psel_i && penable_i && !pready_o |=> pready_o) else $error("late pready");
  a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("long pready");
  a_unmapped_err: assert property
    (pready_o |-> pslverr_o == (paddr_i != `WDT_CTRL_ADDR)) else $error("bad pslverr");
  a_irq_gate: assert property (irq_o |-> $past(global_irq_enable_i) &&
    $past(priority_in_service_i) == `WDT_PRIO_LIMIT) else $error("irq not gated");
  a_rst_gap: assert property (cpu_rst_o |=> !cpu_rst_o [*8]) else $error("reset too soon");
  a_rst_clears: assert property (cpu_rst_o |-> ##2 !irq_o) else $error("flag kept");
  a_reset_quiet: assert property (disable iff (pwr_rst_i)
    sys_rst_i |=> !irq_o && !cpu_rst_o) else $error("busy in reset");
  cover property (cpu_rst_o);
  cover property (irq_o);
  cover property (pready_o && pslverr_o);
endmodule // watchdog_checker

bind watchdog_timer_control watchdog_checker u_watchdog_checker (.*);

/* File: cpu_side_model.sv */
`timescale 1ns/1ns
// ----------------------------------------
// processor side model
// ----------------------------------------
module cpu_side_model (
  // clock and requests
  input  wire logic       ref_clk_i,
  input  wire logic       cpu_rst_i,
  input  wire logic       gie_req_i,
  input  wire logic [1:0] ips_req_i,
  // controller state
  output logic            gie_o = 1'b0,
  output logic [1:0]      ips_o = 2'h3,
  output int              rst_cnt_o = 0
);
  // a processor reset drops the global enable and is counted
  always @(posedge ref_clk_i) begin
    gie_o <= gie_req_i & ~cpu_rst_i;
    ips_o <= ips_req_i;
    rst_cnt_o <= rst_cnt_o + int'(cpu_rst_i);
  end
endmodule // cpu_side_model

/* File: tb_watchdog_timer_control.sv */
`timescale 1ns/1ns
`include "wdt_defs.vh"
module tb_watchdog_timer_control;
  logic        ref_clk_i = 1'b0, sys_rst_i = 1'b1, pwr_rst_i = 1'b1, gie_req = 1'b0;
  logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic        pready_o, pslverr_o, irq_o, cpu_rst_o, gie, er;
  logic [1:0]  priority_in_service, ips_req = 2'h3;
  logic [3:0]  pstrb_i = 4'hF;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  int          err_count = 0, n_tests = 0, cyc = 0, seed = 46140, rcnt, t0, mdl = 8'h80;

  always #4 ref_clk_i = ~ref_clk_i;
  cpu_side_model u_cpu_side_model (.ref_clk_i, .cpu_rst_i(cpu_rst_o), .gie_req_i(gie_req),
    .ips_req_i(ips_req), .gie_o(gie), .ips_o(priority_in_service), .rst_cnt_o(rcnt));
  watchdog_timer_control u_watchdog_timer_control (.ref_clk_i, .clk_en_i(1'b1), .sys_rst_i,
    .pwr_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o,
    .pready_o, .pslverr_o, .global_irq_enable_i(gie), .priority_in_service_i(priority_in_service), .irq_o,
    .cpu_rst_o);

  task chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task print_verdict;
    $display("compares %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // one apb transfer, held until pready
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {$random(seed)} & 32'hFFFFFF00 | d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do @(posedge ref_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task wr(input logic [7:0] d);
    apb(1'b1, `WDT_CTRL_ADDR, d);
    mdl = d & 8'h7A | mdl & d & 8'h84;
  endtask
  task rdc;
    apb(1'b0, `WDT_CTRL_ADDR, 8'h00);
    chk(rd, mdl);
  endtask
  task tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  // hang guard
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      err_count++;
      print_verdict;
    end
  end

  initial begin
    tick(16);
    sys_rst_i <= 1'b0;
    pwr_rst_i <= 1'b0;
    tick(1);
    rdc;
    wr(8'h01);
    rdc;
    pstrb_i <= 4'hE;
    apb(1'b1, `WDT_CTRL_ADDR, 8'h48);
    pstrb_i <= 4'hF;
    for (int w = 0; w < 2; w++) begin
      apb(w[0], 12'($random(seed)) & 12'hFF0 | 12'h004, 8'h48);
      chk(er, 1);
    end
    rdc;
    $display("register access done");
    gie_req <= 1'b1;
    wr(8'h48);
    for (int p = 0; p < 4; p++) begin
      ips_req <= p[1:0];
      tick(3);
      chk(irq_o, p == 3);
    end
    wr(8'h08);
    tick(3);
    chk(irq_o, 0);
    $display("interrupt gating done");
    wr(8'h42);
    tick(20000);
    wr(8'h43);
    t0 = cyc;
    while (irq_o !== 1'b1) tick(1);
    chk($unsigned(cyc - t0 - (1 << 15) + 4) < 9, 1);
    t0 = cyc;
    while (cpu_rst_o !== 1'b1) tick(1);
    chk($unsigned(cyc - t0 - 507) < 8, 1);
    tick(1);
    mdl = mdl & 8'hC6 | 8'h04;
    rdc;
    sys_rst_i <= 1'b1;
    tick(1);
    sys_rst_i <= 1'b0;
    tick(1);
    mdl = mdl & 8'hC6;
    rdc;
    $display("reset timing done");
    while (irq_o !== 1'b1) tick(1);
    wr(8'h44);
    tick(600);
    chk(rcnt, 1);
    rdc;
    $display("reset cancel done");
    print_verdict;
  end
endmodule // tb_watchdog_timer_control
